// ===== hw/sms_defines.svh
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH

// Byte addresses on the register bus
`define SMS_CTRL_OFS 4'h0
`define SMS_DATA_OFS 4'h4

// Control/status field positions
`define SMS_F_RATE_HI 15
`define SMS_F_RATE_LO 13
`define SMS_F_ORDER 12
`define SMS_F_ERRIE 11
`define SMS_F_FDEN 10
`define SMS_F_RXIE 9
`define SMS_F_MSTR 8
`define SMS_F_CPOL 7
`define SMS_F_CPHA 6
`define SMS_F_PEN 5
`define SMS_F_TXIE 4
`define SMS_F_RXFULL 3
`define SMS_F_OVF 2
`define SMS_F_MODE_FAULT_FLAG 1
`define SMS_F_TXEMPTY 0

// Reset values: configuration bits 15..4 and status bits 3..0 (whole word 16'h6141)
`define SMS_CFG_RESET 12'h614
`define SMS_STAT_RESET 4'h1

// Word length and per-word timing
`define SMS_WORD_BITS 5'h10
`define SMS_LAST_BIT 5'h0f
`define SMS_EDGES 6'h20

// Half SCLK period minus one, in clock cycles, per rate code
`define SMS_HALF_DIV2 3'h0
`define SMS_HALF_DIV4 3'h1
`define SMS_HALF_DIV8 3'h3
`define SMS_HALF_DIV16 3'h7

`endif

// ===== hw/sms_pkg.sv
package sms_pkg;

    // Master sequencer, Gray coded along idle -> run -> done; done -> idle flips both bits
    typedef enum logic [1:0] {
        SMS_IDLE = 2'b00,
        SMS_RUN = 2'b01,
        SMS_DONE = 2'b11
    } sms_state_e;

    typedef logic [15:0] sms_word_t;

endpackage

// ===== hw/sms_baud_div.sv
`timescale 1ns/1ns
`default_nettype none
`include "sms_defines.svh"
module sms_baud_div (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [1:0] rateSel,
    output logic tick
);

    logic [2:0] cnt_q;
    logic [2:0] halfLast;

    // Code 10 is undefined; it is given divisor 8 so every code yields a clock
    function automatic logic [2:0] half_last(input logic [1:0] code);
        case (code)
            2'b00: half_last = `SMS_HALF_DIV2;
            2'b01: half_last = `SMS_HALF_DIV4;
            2'b10: half_last = `SMS_HALF_DIV8;
            default: half_last = `SMS_HALF_DIV16;
        endcase
    endfunction

    assign halfLast = half_last(rateSel);
    assign tick = run && (cnt_q == halfLast);

    // Restarting from zero gives the first SCLK edge a full half period of setup
    always_ff @(posedge clk) begin
        if (rst || !run || tick) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_div_four_gap: assert property ((tick && rateSel == 2'b01) |=> !tick ##1 (tick || !run || rateSel != 2'b01))
        else $error("divisor 4 half period wrong");
    a_div_two_rate: assert property ((run && $past(run) && rateSel == 2'b00) |-> tick)
        else $error("divisor 2 must tick every cycle");

endmodule // sms_baud_div

`default_nettype wire

// ===== hw/sms_port.sv
// Operation
// - Drive MISO only when configured slave and select is low.
// - Slave with select high leaves MISO undriven for shared slaves.
// - Master drives SCLK; slave takes SCLK as input.
// - A word takes as many SCLK cycles as it has bits.
// - A slave always takes the select pin as input.
// - Slave with select high ignores every SCLK edge, even mid-word.
// - Select changing during a transfer raises a mode fault.
// - Select pin sets mode fault only with fault detection enabled.
// - Slave with fault detection off never flags mode fault.
// - Select use depends on enable, master and fault detection settings.
// - Master SCLK is bus clock over 2, 4 or 16 by rate code.
// - Rate code resets to 011 and does nothing in slave mode.
// - Master shifts MOSI out and MISO in together.
// - Master select 0 means slave, 1 means master.
// - Master with fault detection stops a transfer when select goes low.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "sms_defines.svh"
module sms_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    input wire logic sclkIn,
    output logic sclkOut,
    output logic sclkOe,
    input wire logic selectNIn,
    output logic selectNOut,
    output logic selectNOe
);

    logic [2:0] rateSel_q;
    logic dataOrder_q;
    logic errIrqEn_q;
    logic faultDetectEn_q;
    logic rxIrqEn_q;
    logic masterSelect_q;
    logic clkPol_q;
    logic clkPha_q;
    logic portEnable_q;
    logic txIrqEn_q;
    logic rxFull_q;
    logic overflow_q;
    logic modeFaultFlag_q;
    logic txEmpty_q;
    sms_pkg::sms_word_t txBuf_q;
    sms_pkg::sms_word_t txShift_q;
    sms_pkg::sms_word_t rxShift_q;
    sms_pkg::sms_word_t rxData_q;
    logic [4:0] bitCnt_q;
    logic [5:0] edgeCnt_q;
    logic mstSclk_q;
    logic sclkPrev_q;
    logic selectPrev_q;
    sms_pkg::sms_state_e state_q;
    sms_pkg::sms_state_e state_d;
    logic tick;

    // Mode and bus decode
    logic masterMode;
    logic slaveActive;
    logic selectLow;
    logic wrOk;
    logic ctrlHit;
    logic dataHit;
    logic wrCtrl;
    logic wrData;
    logic rdData;
    logic [15:0] ctrlWord;
    logic [31:0] readdata_d;

    assign masterMode = portEnable_q && masterSelect_q;
    assign slaveActive = portEnable_q && !masterSelect_q;
    assign selectLow = !selectNIn;
    // Narrow writes are dropped rather than half-applied
    assign wrOk = write && !waitrequest && (byteenable[1:0] == 2'b11);
    assign ctrlHit = (address == `SMS_CTRL_OFS);
    assign dataHit = (address == `SMS_DATA_OFS);
    assign wrCtrl = wrOk && ctrlHit;
    assign wrData = wrOk && dataHit;
    assign rdData = read && !waitrequest && dataHit;
    assign ctrlWord = {rateSel_q, dataOrder_q, errIrqEn_q, faultDetectEn_q, rxIrqEn_q,
        masterSelect_q, clkPol_q, clkPha_q, portEnable_q, txIrqEn_q,
        rxFull_q, overflow_q, modeFaultFlag_q, txEmpty_q};
    assign readdata_d = ctrlHit ? {16'h0000, ctrlWord} :
        (dataHit ? {16'h0000, rxData_q} : 32'h0000_0000);

    // Master sequencing
    logic running;
    logic mstAbort;
    logic mstStart;
    logic mstEdge;
    logic mstLead;
    logic mstFinish;
    logic mstSampleLate_q;

    assign running = (state_q == sms_pkg::SMS_RUN);
    assign mstAbort = masterMode && faultDetectEn_q && selectLow;
    assign mstStart = masterMode && (state_q == sms_pkg::SMS_IDLE) && !txEmpty_q && !mstAbort;
    assign mstEdge = running && tick && (edgeCnt_q != `SMS_EDGES);
    assign mstLead = mstEdge && !edgeCnt_q[0];
    assign mstFinish = running && tick && (edgeCnt_q == `SMS_EDGES);

    // Slave edge detection; pins are synchronous to clk
    logic sclkRise;
    logic sclkFall;
    logic slvEdge;
    logic slvLead;
    logic selectChange;
    logic slvStart;
    logic slvAbort;

    assign sclkRise = sclkIn && !sclkPrev_q;
    assign sclkFall = !sclkIn && sclkPrev_q;
    assign slvEdge = slaveActive && selectLow && (sclkRise || sclkFall);
    assign slvLead = slvEdge && (clkPol_q ? sclkFall : sclkRise);
    assign selectChange = selectNIn ^ selectPrev_q;
    assign slvStart = slaveActive && selectLow && selectPrev_q;
    assign slvAbort = slaveActive && selectNIn && (bitCnt_q != 5'h00);

    // Shared shifter; CPHA 0 samples on the leading edge, CPHA 1 on the trailing
    logic anyEdge;
    logic leadEdge;
    logic sampleNow;
    logic shiftNow;
    logic inBit;
    logic outBit;
    logic slvDone;
    logic xferDone;
    logic loadNow;
    logic modeFaultSet;
    sms_pkg::sms_word_t rxNext;
    sms_pkg::sms_word_t rxWord;
    sms_pkg::sms_word_t txNext;

    assign anyEdge = mstEdge || slvEdge;
    assign leadEdge = mstLead || slvLead;
    // SCLK reaches the pin a cycle after the sequencer edge, so the master samples a cycle late
    assign sampleNow = mstSampleLate_q || (slvEdge && (slvLead ^ clkPha_q));
    // The first CPHA 1 leading edge presents the loaded bit instead of shifting
    assign shiftNow = anyEdge && !(leadEdge ^ clkPha_q)
        && (masterMode ? (edgeCnt_q != 6'h00) : (bitCnt_q != 5'h00));
    assign inBit = masterMode ? misoIn : mosiIn;
    assign outBit = dataOrder_q ? txShift_q[0] : txShift_q[15];
    assign rxNext = dataOrder_q ? {inBit, rxShift_q[15:1]} : {rxShift_q[14:0], inBit};
    assign txNext = dataOrder_q ? {1'b0, txShift_q[15:1]} : {txShift_q[14:0], 1'b0};
    assign slvDone = slaveActive && sampleNow && (bitCnt_q == `SMS_LAST_BIT);
    assign xferDone = slvDone || (state_q == sms_pkg::SMS_DONE);
    assign rxWord = slvDone ? rxNext : rxShift_q;
    assign loadNow = mstStart || (slaveActive && (slvStart || slvDone));
    assign modeFaultSet = faultDetectEn_q && ((masterMode && selectLow)
        || (slaveActive && selectChange && (bitCnt_q != 5'h00)));

    sms_baud_div u_div (
        .clk(clk),
        .rst(rst),
        .run(running),
        .rateSel(rateSel_q[1:0]),
        .tick(tick)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            {rateSel_q, dataOrder_q, errIrqEn_q, faultDetectEn_q, rxIrqEn_q, masterSelect_q,
                clkPol_q, clkPha_q, portEnable_q, txIrqEn_q} <= `SMS_CFG_RESET;
        end else if (wrCtrl) begin
            {rateSel_q, dataOrder_q, errIrqEn_q, faultDetectEn_q, rxIrqEn_q, masterSelect_q,
                clkPol_q, clkPha_q, portEnable_q, txIrqEn_q} <= writedata[15:4];
        end
    end

    // Hardware set wins over a clear in the same cycle, except that a wrData clear of txEmpty_q wins over the loadNow set
    always_ff @(posedge clk) begin
        if (rst) begin
            {rxFull_q, overflow_q, modeFaultFlag_q, txEmpty_q} <= `SMS_STAT_RESET;
        end else begin
            if (xferDone) begin
                rxFull_q <= 1'b1;
            end else if (rdData) begin
                rxFull_q <= 1'b0;
            end
            if (xferDone && rxFull_q && !rdData) begin
                overflow_q <= 1'b1;
            end else if (wrCtrl && writedata[`SMS_F_OVF]) begin
                overflow_q <= 1'b0;
            end
            if (modeFaultSet) begin
                modeFaultFlag_q <= 1'b1;
            end else if (wrCtrl && writedata[`SMS_F_MODE_FAULT_FLAG]) begin
                modeFaultFlag_q <= 1'b0;
            end
            if (wrData) begin
                txEmpty_q <= 1'b0;
            end else if (loadNow) begin
                txEmpty_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txBuf_q <= 16'h0000;
            rxData_q <= 16'h0000;
        end else begin
            if (wrData) begin
                txBuf_q <= writedata[15:0];
            end
            if (xferDone) begin
                rxData_q <= rxWord;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txShift_q <= 16'h0000;
            rxShift_q <= 16'h0000;
            bitCnt_q <= 5'h00;
        end else if (mstAbort || slvAbort || !portEnable_q) begin
            bitCnt_q <= 5'h00;
        end else if (loadNow) begin
            txShift_q <= txBuf_q;
            bitCnt_q <= 5'h00;
        end else begin
            if (sampleNow) begin
                rxShift_q <= rxNext;
                bitCnt_q <= bitCnt_q + 5'h01;
            end
            if (shiftNow) begin
                txShift_q <= txNext;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            sms_pkg::SMS_IDLE: begin
                if (mstStart) begin
                    state_d = sms_pkg::SMS_RUN;
                end
            end
            sms_pkg::SMS_RUN: begin
                if (mstFinish) begin
                    state_d = sms_pkg::SMS_DONE;
                end
            end
            sms_pkg::SMS_DONE: begin
                state_d = sms_pkg::SMS_IDLE;
            end
            default: begin
                state_d = sms_pkg::SMS_IDLE;
            end
        endcase
        if (mstAbort || !masterMode) begin
            state_d = sms_pkg::SMS_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= sms_pkg::SMS_IDLE;
            edgeCnt_q <= 6'h00;
            mstSclk_q <= 1'b0;
            mstSampleLate_q <= 1'b0;
        end else begin
            state_q <= state_d;
            edgeCnt_q <= (!running) ? 6'h00 : (mstEdge ? edgeCnt_q + 6'h01 : edgeCnt_q);
            mstSclk_q <= (!running) ? clkPol_q : (mstEdge ? !mstSclk_q : mstSclk_q);
            mstSampleLate_q <= mstEdge && !mstAbort && (mstLead ^ clkPha_q);
        end
    end

    // Pins are registered; a fault also drops the master drivers to avoid contention
    always_ff @(posedge clk) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
            selectPrev_q <= 1'b1;
            mosiOut <= 1'b0;
            mosiOe <= 1'b0;
            misoOut <= 1'b0;
            misoOe <= 1'b0;
            sclkOut <= 1'b0;
            sclkOe <= 1'b0;
            selectNOut <= 1'b1;
            selectNOe <= 1'b0;
        end else begin
            sclkPrev_q <= sclkIn;
            selectPrev_q <= selectNIn;
            mosiOut <= outBit;
            mosiOe <= masterMode && !modeFaultFlag_q;
            misoOut <= outBit;
            misoOe <= slaveActive && selectLow;
            sclkOut <= mstSclk_q;
            sclkOe <= masterMode && !modeFaultFlag_q;
            selectNOut <= !running;
            selectNOe <= masterMode && !faultDetectEn_q;
        end
    end

    // One wait state on every access
    always_ff @(posedge clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            readdata <= readdata_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_miso_slave_only: assert property (misoOe |-> $past(slaveActive && selectLow))
        else $error("MISO driven outside selected slave");
    a_miso_float_high: assert property ((slaveActive && selectNIn) |=> !misoOe)
        else $error("MISO driven with select high");
    a_sclk_master_drive: assert property ($past(masterMode && !modeFaultFlag_q) |-> sclkOe)
        else $error("master not driving SCLK");
    a_sclk_slave_input: assert property ($past(!masterMode) |-> !sclkOe)
        else $error("SCLK driven when not master");
    a_word_bit_count: assert property ((state_q == sms_pkg::SMS_DONE) |-> (bitCnt_q == `SMS_WORD_BITS))
        else $error("master word not sixteen bits");
    a_select_slave_in: assert property ($past(slaveActive) |-> !selectNOe)
        else $error("slave driving select");
    a_slave_ignores_sclk: assert property ((slaveActive && selectNIn && $past(slaveActive && selectNIn)) |-> (bitCnt_q == 5'h00))
        else $error("slave counted edges with select high");
    a_fault_on_change: assert property ((slaveActive && faultDetectEn_q && selectChange && bitCnt_q != 5'h00) |=> modeFaultFlag_q)
        else $error("mid-word select change not flagged");
    a_fault_needs_enable: assert property ($rose(modeFaultFlag_q) |-> $past(faultDetectEn_q))
        else $error("mode fault set while detection off");
    a_fault_abort: assert property ((running && mstAbort) |=> (state_q == sms_pkg::SMS_IDLE))
        else $error("master kept running after fault");
    a_rate_reset: assert property ($past(rst) |-> (rateSel_q == 3'b011))
        else $error("rate code reset value wrong");
    a_div_sixteen: assert property ((tick && rateSel_q[1:0] == 2'b11) |=> (!tick)[*7] ##1 (tick || !running || rateSel_q[1:0] != 2'b11))
        else $error("divisor 16 half period wrong");

    c_master_word: cover property (state_q == sms_pkg::SMS_DONE);
    c_slave_word: cover property (slvDone);
    c_mode_fault: cover property (modeFaultSet && running);
    c_overflow: cover property ($rose(overflow_q));

endmodule // sms_port

`default_nettype wire

// ===== sim/sms_spi_partner.sv
`timescale 1ns/1ns
`default_nettype none
module sms_spi_partner (
    input wire logic clk,
    input wire logic sclkPin,
    input wire logic mosiPin,
    input wire logic misoPin,
    input wire logic ssNPin,
    output logic pSclk,
    output logic pMosi,
    output logic pMiso,
    output logic pSsN
);
    localparam logic [15:0] SLV_TX = 16'h3c5a;
    logic busy;
    logic [4:0] bitCnt;
    logic [15:0] slvRx;
    logic [15:0] mstRx;
    initial begin
        busy = 1'h0;
        pSclk = 1'h0;
        pMosi = 1'h0;
        pMiso = 1'h0;
        pSsN = 1'h1;
        bitCnt = 5'h0;
    end
    // Released lines toggle so a stale level never passes for data
    always @(posedge clk) begin
        if (!busy) pMosi <= ~pMosi;
        if (ssNPin) pMiso <= ~pMiso;
        if (ssNPin) bitCnt <= 5'h0;
    end
    // Slave role: launch on leading edge, sample on trailing edge
    always @(posedge sclkPin) begin
        if (!ssNPin) begin
            pMiso <= SLV_TX[4'hf - bitCnt[3:0]];
            bitCnt <= bitCnt + 5'h1;
        end
    end
    always @(negedge sclkPin) begin
        if (!ssNPin) slvRx <= {slvRx[14:0], mosiPin};
    end
    task automatic setSs(input logic lvl);
        pSsN <= lvl;
    endtask
    // Master role; nBits below 16 cuts a word short on purpose
    task automatic xfer(input logic [15:0] w, input int nBits, input logic selNow);
        busy <= 1'h1;
        pSsN <= ~selNow;
        repeat (4) @(posedge clk);
        for (int i = 0; i < nBits; i++) begin
            pMosi <= w[15 - i];
            pSclk <= 1'h1;
            repeat (4) @(posedge clk);
            mstRx <= {mstRx[14:0], misoPin};
            pSclk <= 1'h0;
            repeat (4) @(posedge clk);
        end
        pSsN <= 1'h1;
        busy <= 1'h0;
        repeat (4) @(posedge clk);
    endtask
endmodule // sms_spi_partner
`default_nettype wire

// ===== sim/sms_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sms_port_tb;
    logic clk, rst, read, write, waitrequest;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, rd;
    logic mosiOut, mosiOe, misoOut, misoOe, sclkOut, sclkOe, selectNOut, selectNOe;
    logic pSclk, pMosi, pMiso, pSsN, prevSclk;
    int failures, checks_done, edges, half, gap;
    wire mosiPin = mosiOe ? mosiOut : pMosi;
    wire misoPin = misoOe ? misoOut : pMiso;
    wire sclkPin = sclkOe ? sclkOut : pSclk;
    wire ssNPin = selectNOe ? selectNOut : pSsN;

    sms_port i_sms_port (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .mosiIn(mosiPin),
        .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoPin), .misoOut(misoOut),
        .misoOe(misoOe), .sclkIn(sclkPin), .sclkOut(sclkOut), .sclkOe(sclkOe),
        .selectNIn(ssNPin), .selectNOut(selectNOut), .selectNOe(selectNOe));
    sms_spi_partner i_sms_spi_partner (.clk(clk), .sclkPin(sclkPin),
        .mosiPin(mosiPin), .misoPin(misoPin), .ssNPin(ssNPin), .pSclk(pSclk),
        .pMosi(pMosi), .pMiso(pMiso), .pSsN(pSsN));

    always #2 clk = ~clk;
    // Count master clock toggles and the spacing of the latest pair
    always @(posedge clk) begin
        prevSclk <= sclkOut;
        gap <= (sclkOut != prevSclk) ? 1 : gap + 1;
        if (sclkOut != prevSclk) begin
            edges <= edges + 1;
            half <= gap;
        end
    end

    task automatic end_sim;
        $display("Counts: checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t flag got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
        int n;
        address <= a;
        writedata <= {16'h0, d};
        byteenable <= 4'hf;
        write <= wr;
        read <= ~wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'h0 && n < 50);
        rd = readdata;
        read <= 1'h0;
        write <= 1'h0;
        if (waitrequest !== 1'h0) begin
            failures++;
            end_sim();
        end
        @(posedge clk);
    endtask
    task automatic wrw(input logic [3:0] a, input logic [15:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic rdw(input logic [3:0] a);
        bus(1'h0, a, 16'h0);
    endtask

    task automatic t_reset;
        rdw(4'h0);
        chk(rd[15:0], 16'h6141);
        rdw(4'h8);
        chk(rd[15:0], 16'h0);
        chkb(selectNOe, 1'h0);
        chkb(sclkOe, 1'h0);
        $display("done reset values");
    endtask
    task automatic t_master(input logic [1:0] code, input int expHalf);
        int e0;
        int n;
        wrw(4'h0, {1'h0, code, 13'h0160});
        e0 = edges;
        wrw(4'h4, 16'ha5c3);
        n = 0;
        do begin
            rdw(4'h0);
            n++;
        end while (rd[3] !== 1'h1 && n < 200);
        if (rd[3] !== 1'h1) begin
            failures++;
            end_sim();
        end
        chk(16'(edges - e0), 16'h20);
        chk(16'(half), 16'(expHalf));
        chkb(sclkOe, 1'h1);
        chkb(selectNOe, 1'h1);
        chkb(misoOe, 1'h0);
        chk(i_sms_spi_partner.slvRx, 16'ha5c3);
        rdw(4'h4);
        chk(rd[15:0], 16'h3c5a);
        $display("done master rate code %0d", code);
    endtask
    task automatic t_fault;
        wrw(4'h0, 16'h6560);
        wrw(4'h4, 16'h1234);
        repeat (10) @(posedge clk);
        i_sms_spi_partner.setSs(1'h0);
        repeat (3) @(posedge clk);
        chkb(sclkOe, 1'h0);
        chkb(mosiOe, 1'h0);
        i_sms_spi_partner.setSs(1'h1);
        rdw(4'h0);
        chkb(rd[1], 1'h1);
        wrw(4'h0, 16'h6562);
        rdw(4'h0);
        chkb(rd[1], 1'h0);
        $display("done master mode fault");
    endtask
    task automatic t_slave(input logic fden);
        wrw(4'h0, {5'h0, fden, 10'h060});
        wrw(4'h4, 16'h5e71);
        chkb(misoOe, 1'h0);
        chkb(sclkOe, 1'h0);
        chkb(selectNOe, 1'h0);
        // Clock edges with select high must leave no trace
        i_sms_spi_partner.xfer(16'hffff, 16, 1'h0);
        rdw(4'h0);
        chkb(rd[3], 1'h0);
        i_sms_spi_partner.xfer(16'hc3a5, 16, 1'h1);
        rdw(4'h4);
        chk(rd[15:0], 16'hc3a5);
        chk(i_sms_spi_partner.mstRx, 16'h5e71);
        chkb(misoOe, 1'h0);
        i_sms_spi_partner.xfer(16'h0f0f, 8, 1'h1);
        rdw(4'h0);
        chkb(rd[1], fden);
        wrw(4'h0, {5'h0, fden, 10'h062});
        $display("done slave, fault detect %0d", fden);
    endtask

    initial begin
        clk = 1'h0;
        rst = 1'h1;
        read = 1'h0;
        write = 1'h0;
        address = 4'h0;
        writedata = 32'h0;
        byteenable = 4'h0;
        failures = 0;
        checks_done = 0;
        edges = 0;
        gap = 0;
        half = 0;
        prevSclk = 1'h0;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        t_reset();
        t_master(2'h0, 1);
        t_master(2'h1, 2);
        t_master(2'h3, 8);
        t_fault();
        t_slave(1'h1);
        t_slave(1'h0);
        end_sim();
    end
endmodule // sms_port_tb
`default_nettype wire
